// [src/cscall_pkg.sv]
// Package for the conditional subroutine-call execution block
`default_nettype none
package cscall_pkg;
  localparam int          WORD_W       = 24;
  // Opcode byte patterns, bits 23 to 16
  localparam logic [7:0]  OPC_CC_SHORT = 8'h0f;
  localparam logic [7:0]  OPC_MAIN     = 8'h0b;
  localparam logic [7:0]  OPC_CLR_IOQ  = 8'h01;
  localparam logic [3:0]  CC_EA_TAG    = 4'ha;
  // Field positions
  localparam int          OPC_LSB      = 16;
  localparam int          FORM_LSB     = 14;
  localparam int          FIELD6_LSB   = 8;
  localparam int          CC_SHORT_LSB = 12;
  localparam int          SPACE_BIT    = 6;
  localparam int          MEMFORM_BIT  = 7;
  localparam int          CLR_ZERO_BIT = 5;
  localparam int          SHORT_ADDR_W = 12;
  localparam int          BIT_FIELD_W  = 4;
  localparam int          BIT_MAX      = 23;
  // Addressing forms of the bit-clear call, bits 15 to 14
  localparam logic [1:0]  FORM_ABS     = 2'b00;
  localparam logic [1:0]  FORM_EA      = 2'b01;
  localparam logic [1:0]  FORM_IOP     = 2'b10;
  localparam logic [1:0]  FORM_REG     = 2'b11;
  // I/O short ranges, 64 words each
  localparam logic [23:0] IO_HIGH_BASE = 24'hffffc0;
  localparam logic [23:0] IO_LOW_BASE  = 24'hffff80;
  // Reset values and instruction lengths in words
  localparam logic [23:0] WORD_RST     = 24'h000000;
  localparam logic [5:0]  FIELD6_RST   = 6'h00;
  localparam logic [3:0]  NIB_RST      = 4'h0;
  localparam logic [1:0]  LEN_ONE      = 2'h1;
  localparam logic [1:0]  LEN_TWO      = 2'h2;

  typedef enum logic [1:0] {
    CSCALL_OP_ABS,
    CSCALL_OP_IO_HIGH,
    CSCALL_OP_IO_LOW
  } cscall_short_t;
endpackage : cscall_pkg
`default_nettype wire

// [src/cscall_bit_unit.sv]
// Operand address former and bit tester for the bit-clear call
`default_nettype none
module cscall_bit_unit #(
  parameter int WORD_W = 24,
  parameter int BIT_W  = 4
) (
  input  wire logic                  [5:0] short_field, // Six-bit short address
  input  wire cscall_pkg::cscall_short_t   short_kind,  // Absolute or I/O range
  input  wire logic           [WORD_W-1:0] operand,     // Source operand value
  input  wire logic            [BIT_W-1:0] bit_sel,     // Bit number field
  output logic                [WORD_W-1:0] short_addr,  // Formed operand address
  output logic                             bit_clear    // Tested bit is zero
);
  if (WORD_W != 24 || (1 << BIT_W) > WORD_W * 2) begin : g_bad_width
    $error("cscall_bit_unit: unsupported widths");
  end

  always_comb begin
    case (short_kind)
      cscall_pkg::CSCALL_OP_IO_HIGH: short_addr = cscall_pkg::IO_HIGH_BASE | {18'h0, short_field};
      cscall_pkg::CSCALL_OP_IO_LOW:  short_addr = cscall_pkg::IO_LOW_BASE | {18'h0, short_field};
      default:                       short_addr = {18'h0, short_field};
    endcase
  end

  assign bit_clear = ~operand[bit_sel];
endmodule : cscall_bit_unit
`default_nettype wire

// [src/cscall_exec.sv]
// Execution logic for the condition-code and bit-clear subroutine calls
//
// Behaviour
// - Taken conditional call increments SP, pushes, branches.
// - Conditional call target is effective address.
// - False condition: PC advances, nothing pushed.
// - Conditional call address update always happens.
// - Short form zero-extends twelve-bit target.
// - Conditional call takes memory-alterable modes, short.
// - Conditional call leaves condition codes unchanged.
// - Bit-clear call tests immediate-selected operand bit.
// - Clear bit pushes, then jumps to extension.
// - Bit-clear call always carries extension word.
// - Set bit: PC advances, no push, no branch.
// - Bit-clear address update regardless of bit.
// - Operand via indirect, absolute, I/O short.
// - Register form tests any on-chip register.
// - Only scaling and limit flags are updated.
`default_nettype none
module cscall_exec #(
  parameter int WORD_W = 24,
  parameter int BIT_W  = 4
) (
  input  wire logic              clk,             // Core clock
  input  wire logic              rst_n,           // Asynchronous reset
  input  wire logic              instr_valid,     // Opcode word offered
  input  wire logic [WORD_W-1:0] instr_word,      // Opcode word
  input  wire logic [WORD_W-1:0] instr_addr,      // Address of the opcode word
  input  wire logic              ext_valid,       // Extension word offered
  input  wire logic [WORD_W-1:0] ext_word,        // Extension word
  input  wire logic              agu_ack,         // Address unit finished
  input  wire logic [WORD_W-1:0] agu_ea,          // Effective address computed
  input  wire logic              agu_has_ext,     // Mode used an extension word
  input  wire logic              cond_true,       // Condition for cond_sel holds
  input  wire logic              op_ack,          // Operand delivered
  input  wire logic [WORD_W-1:0] op_data,         // Operand value
  input  wire logic              op_growth,       // Data growth on the transfer
  input  wire logic              op_limit,        // Limiting on the transfer
  input  wire logic [WORD_W-1:0] status_word,     // Current status word
  output logic                   busy,            // Instruction in progress
  output logic                   accept,          // Opcode taken, pulse
  output logic                   agu_req,         // Address unit request, pulse
  output logic             [5:0] effective_address_field, // Mode and register
  output logic             [3:0] cond_sel,        // Condition to evaluate
  output logic                   op_req,          // Operand request, pulse
  output logic                   op_is_reg,       // Operand is a register
  output logic                   op_space_y,      // Operand in Y space
  output logic      [WORD_W-1:0] op_addr,         // Operand address
  output logic             [5:0] op_reg,          // Source register code
  output logic                   sp_inc,          // Stack pointer increment, pulse
  output logic                   stack_push,      // Push strobe, pulse
  output logic      [WORD_W-1:0] stack_high_word, // Return address pushed
  output logic      [WORD_W-1:0] stack_low_word,  // Status word pushed
  output logic                   pc_load,         // Program counter load, pulse
  output logic      [WORD_W-1:0] pc_value,        // New program counter
  output logic                   flag_we,         // Scaling/limit write, pulse
  output logic                   scale_flag,      // Scaling flag value
  output logic                   limit_flag       // Limit flag value
);
  if (WORD_W != cscall_pkg::WORD_W || BIT_W != cscall_pkg::BIT_FIELD_W) begin : g_bad_width
    $error("cscall_exec: widths must match the instruction format");
  end

  typedef enum logic [2:0] {
    CSCALL_IDLE,
    CSCALL_EA,
    CSCALL_OPND,
    CSCALL_EXT,
    CSCALL_EXEC
  } cscall_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [7:0]                opc;
  logic [1:0]                form;
  logic [5:0]                f6;
  logic                      dec_cc_short;
  logic                      dec_cc_ea;
  logic                      dec_clr_main;
  logic                      dec_clr_ioq;
  cscall_pkg::cscall_short_t short_kind_nxt;
  logic [WORD_W-1:0]         short_addr;
  logic                      bit_clear;

  assign opc  = instr_word[cscall_pkg::OPC_LSB +: 8];
  assign form = instr_word[cscall_pkg::FORM_LSB +: 2];
  assign f6   = instr_word[cscall_pkg::FIELD6_LSB +: 6];
  assign dec_cc_short = opc == cscall_pkg::OPC_CC_SHORT;
  assign dec_cc_ea    = opc == cscall_pkg::OPC_MAIN && form == cscall_pkg::FORM_REG
                        && instr_word[7:4] == cscall_pkg::CC_EA_TAG;
  assign dec_clr_main = opc == cscall_pkg::OPC_MAIN
                        && !instr_word[cscall_pkg::CLR_ZERO_BIT]
                        && !instr_word[4]
                        && (form != cscall_pkg::FORM_REG
                            ? instr_word[cscall_pkg::MEMFORM_BIT]
                            : !instr_word[cscall_pkg::MEMFORM_BIT]
                              && !instr_word[cscall_pkg::SPACE_BIT]);
  assign dec_clr_ioq  = opc == cscall_pkg::OPC_CLR_IOQ && form == cscall_pkg::FORM_REG
                        && !instr_word[cscall_pkg::CLR_ZERO_BIT]
                        && !instr_word[4]
                        && instr_word[cscall_pkg::MEMFORM_BIT];

  always_comb begin
    if (dec_clr_ioq) begin
      short_kind_nxt = cscall_pkg::CSCALL_OP_IO_LOW;
    end else if (form == cscall_pkg::FORM_IOP) begin
      short_kind_nxt = cscall_pkg::CSCALL_OP_IO_HIGH;
    end else begin
      short_kind_nxt = cscall_pkg::CSCALL_OP_ABS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand path
  logic [BIT_W-1:0] bit_sel_r;
  logic [BIT_W-1:0] bit_sel_nxt;

  cscall_bit_unit #(
    .WORD_W (WORD_W),
    .BIT_W  (BIT_W)
  ) u_bit (
    .short_field (f6),
    .short_kind  (short_kind_nxt),
    .operand     (op_data),
    .bit_sel     (bit_sel_r),
    .short_addr  (short_addr),
    .bit_clear   (bit_clear)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing
  cscall_state_t     state_r, state_nxt;
  logic              is_clr_r, is_clr_nxt;
  logic              taken_r, taken_nxt;
  logic [1:0]        len_r, len_nxt;
  logic [WORD_W-1:0] target_r, target_nxt;
  logic [WORD_W-1:0] ret_addr;
  logic              busy_nxt, accept_nxt, agu_req_nxt, op_req_nxt;
  logic              op_is_reg_nxt, op_space_y_nxt;
  logic [5:0]        eaf_nxt, op_reg_nxt;
  logic [3:0]        cond_sel_nxt;
  logic [WORD_W-1:0] op_addr_nxt;
  logic              sp_inc_nxt, push_nxt, pc_load_nxt, flag_we_nxt;
  logic [WORD_W-1:0] ssh_nxt, ssl_nxt, pc_value_nxt;
  logic              scale_nxt, limit_nxt;

  assign ret_addr = instr_addr + {{(WORD_W-2){1'b0}}, len_r};

  always_comb begin
    state_nxt      = state_r;
    is_clr_nxt     = is_clr_r;
    taken_nxt      = taken_r;
    len_nxt        = len_r;
    target_nxt     = target_r;
    bit_sel_nxt    = bit_sel_r;
    eaf_nxt        = effective_address_field;
    cond_sel_nxt   = cond_sel;
    op_is_reg_nxt  = op_is_reg;
    op_space_y_nxt = op_space_y;
    op_addr_nxt    = op_addr;
    op_reg_nxt     = op_reg;
    ssh_nxt        = stack_high_word;
    ssl_nxt        = stack_low_word;
    pc_value_nxt   = pc_value;
    scale_nxt      = scale_flag;
    limit_nxt      = limit_flag;
    accept_nxt     = 1'b0;
    agu_req_nxt    = 1'b0;
    op_req_nxt     = 1'b0;
    sp_inc_nxt     = 1'b0;
    push_nxt       = 1'b0;
    pc_load_nxt    = 1'b0;
    flag_we_nxt    = 1'b0;
    case (state_r)
      CSCALL_IDLE: begin
        if (instr_valid && (dec_cc_short || dec_cc_ea || dec_clr_main || dec_clr_ioq)) begin
          accept_nxt     = 1'b1;
          is_clr_nxt     = dec_clr_main || dec_clr_ioq;
          bit_sel_nxt    = instr_word[BIT_W-1:0];
          eaf_nxt        = f6;
          op_space_y_nxt = instr_word[cscall_pkg::SPACE_BIT];
          op_reg_nxt     = f6;
          op_is_reg_nxt  = dec_clr_main && form == cscall_pkg::FORM_REG;
          len_nxt        = cscall_pkg::LEN_ONE;
          if (dec_cc_short) begin
            cond_sel_nxt = instr_word[cscall_pkg::CC_SHORT_LSB +: 4];
            target_nxt   = {{(WORD_W-cscall_pkg::SHORT_ADDR_W){1'b0}},
                            instr_word[cscall_pkg::SHORT_ADDR_W-1:0]};
            state_nxt    = CSCALL_EXEC;
          end else if (dec_cc_ea) begin
            cond_sel_nxt = instr_word[3:0];
            agu_req_nxt  = 1'b1;
            state_nxt    = CSCALL_EA;
          end else if (dec_clr_main && form == cscall_pkg::FORM_EA) begin
            agu_req_nxt  = 1'b1;
            state_nxt    = CSCALL_EA;
          end else begin
            op_addr_nxt  = short_addr;
            op_req_nxt   = 1'b1;
            state_nxt    = CSCALL_OPND;
          end
        end
      end
      CSCALL_EA: begin
        if (agu_ack) begin
          if (is_clr_r) begin
            op_addr_nxt = agu_ea;
            op_req_nxt  = 1'b1;
            state_nxt   = CSCALL_OPND;
          end else begin
            target_nxt  = agu_ea;
            len_nxt     = agu_has_ext ? cscall_pkg::LEN_TWO : cscall_pkg::LEN_ONE;
            state_nxt   = CSCALL_EXEC;
          end
        end
      end
      CSCALL_OPND: begin
        if (op_ack) begin
          taken_nxt   = bit_clear;
          flag_we_nxt = 1'b1;
          scale_nxt   = status_word[7] | op_growth;
          limit_nxt   = status_word[6] | op_limit;
          state_nxt   = CSCALL_EXT;
        end
      end
      CSCALL_EXT: begin
        if (ext_valid) begin
          target_nxt = ext_word;
          len_nxt    = cscall_pkg::LEN_TWO;
          state_nxt  = CSCALL_EXEC;
        end
      end
      CSCALL_EXEC: begin
        pc_load_nxt = 1'b1;
        state_nxt   = CSCALL_IDLE;
        if (is_clr_r ? taken_r : cond_true) begin
          sp_inc_nxt   = 1'b1;
          push_nxt     = 1'b1;
          ssh_nxt      = ret_addr;
          ssl_nxt      = status_word;
          pc_value_nxt = target_r;
        end else begin
          pc_value_nxt = ret_addr;
        end
      end
      default: state_nxt = CSCALL_IDLE;
    endcase
    busy_nxt = state_nxt != CSCALL_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r                 <= CSCALL_IDLE;
      is_clr_r                <= 1'b0;
      taken_r                 <= 1'b0;
      len_r                   <= cscall_pkg::LEN_ONE;
      target_r                <= cscall_pkg::WORD_RST;
      bit_sel_r               <= cscall_pkg::NIB_RST;
      busy                    <= 1'b0;
      accept                  <= 1'b0;
      agu_req                 <= 1'b0;
      effective_address_field <= cscall_pkg::FIELD6_RST;
      cond_sel                <= cscall_pkg::NIB_RST;
      op_req                  <= 1'b0;
      op_is_reg               <= 1'b0;
      op_space_y              <= 1'b0;
      op_addr                 <= cscall_pkg::WORD_RST;
      op_reg                  <= cscall_pkg::FIELD6_RST;
      sp_inc                  <= 1'b0;
      stack_push              <= 1'b0;
      stack_high_word         <= cscall_pkg::WORD_RST;
      stack_low_word          <= cscall_pkg::WORD_RST;
      pc_load                 <= 1'b0;
      pc_value                <= cscall_pkg::WORD_RST;
      flag_we                 <= 1'b0;
      scale_flag              <= 1'b0;
      limit_flag              <= 1'b0;
    end else begin
      state_r                 <= state_nxt;
      is_clr_r                <= is_clr_nxt;
      taken_r                 <= taken_nxt;
      len_r                   <= len_nxt;
      target_r                <= target_nxt;
      bit_sel_r               <= bit_sel_nxt;
      busy                    <= busy_nxt;
      accept                  <= accept_nxt;
      agu_req                 <= agu_req_nxt;
      effective_address_field <= eaf_nxt;
      cond_sel                <= cond_sel_nxt;
      op_req                  <= op_req_nxt;
      op_is_reg               <= op_is_reg_nxt;
      op_space_y              <= op_space_y_nxt;
      op_addr                 <= op_addr_nxt;
      op_reg                  <= op_reg_nxt;
      sp_inc                  <= sp_inc_nxt;
      stack_push              <= push_nxt;
      stack_high_word         <= ssh_nxt;
      stack_low_word          <= ssl_nxt;
      pc_load                 <= pc_load_nxt;
      pc_value                <= pc_value_nxt;
      flag_we                 <= flag_we_nxt;
      scale_flag              <= scale_nxt;
      limit_flag              <= limit_nxt;
    end
  end
endmodule : cscall_exec
`default_nettype wire

// [verif/cscall_exec_checker.sv]
// Port-level assertions for the subroutine-call execution block
`default_nettype none
module cscall_exec_checker #(
  parameter int WORD_W = 24
) (
  input wire logic              clk,             // Core clock
  input wire logic              rst_n,           // Asynchronous reset
  input wire logic              instr_valid,     // Opcode offered
  input wire logic [WORD_W-1:0] instr_word,      // Opcode word
  input wire logic [WORD_W-1:0] instr_addr,      // Opcode address
  input wire logic              op_ack,          // Operand delivered
  input wire logic              op_growth,       // Growth detect
  input wire logic              op_limit,        // Limit detect
  input wire logic [WORD_W-1:0] status_word,     // Status word
  input wire logic              busy,            // In progress
  input wire logic              accept,          // Opcode taken
  input wire logic              sp_inc,          // Stack increment
  input wire logic              stack_push,      // Push strobe
  input wire logic [WORD_W-1:0] stack_high_word, // Return address
  input wire logic [WORD_W-1:0] stack_low_word,  // Pushed status
  input wire logic              pc_load,         // PC load
  input wire logic [WORD_W-1:0] pc_value,        // New PC
  input wire logic              flag_we,         // Flag write
  input wire logic              scale_flag,      // New scaling flag
  input wire logic              limit_flag       // New limit flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_accept_needs_offer: assert property (accept |-> $past(instr_valid) && !$past(busy))
    else $error("accept without an idle offer");
  a_push_with_inc: assert property (stack_push |-> sp_inc && pc_load)
    else $error("push without increment and load");
  a_inc_only_push: assert property (sp_inc |-> stack_push)
    else $error("increment without push");
  a_push_words: assert property (stack_push |-> stack_low_word == $past(status_word)
    && (stack_high_word == instr_addr + 24'h1 || stack_high_word == instr_addr + 24'h2))
    else $error("wrong stacked words");
  a_short_call_target: assert property (accept && $past(instr_word[23:16]) == 8'h0f
    |=> pc_load && (stack_push ? pc_value == {12'h000, $past(instr_word[11:0], 2)}
    : pc_value == instr_addr + 24'h1))
    else $error("short call target or timing wrong");
  a_skip_steps_pc: assert property (pc_load && !stack_push
    |-> pc_value == instr_addr + 24'h1 || pc_value == instr_addr + 24'h2)
    else $error("skip address wrong");
  a_flags_from_op: assert property (flag_we |-> $past(op_ack)
    && scale_flag == ($past(status_word[7]) | $past(op_growth))
    && limit_flag == ($past(status_word[6]) | $past(op_limit)))
    else $error("scaling or limit flag wrong");
  a_load_ends_busy: assert property (pc_load |-> !busy && $past(busy))
    else $error("busy not ended by load");

  c_push: cover property (stack_push);
  c_flags: cover property (flag_we);
  c_skip: cover property (pc_load && !stack_push);
endmodule : cscall_exec_checker

bind cscall_exec cscall_exec_checker #(.WORD_W(WORD_W)) i_chk (
  .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_addr(instr_addr), .op_ack(op_ack), .op_growth(op_growth), .op_limit(op_limit),
  .status_word(status_word), .busy(busy), .accept(accept), .sp_inc(sp_inc),
  .stack_push(stack_push), .stack_high_word(stack_high_word),
  .stack_low_word(stack_low_word), .pc_load(pc_load), .pc_value(pc_value),
  .flag_we(flag_we), .scale_flag(scale_flag), .limit_flag(limit_flag));
`default_nettype wire

// [verif/cscall_exec_tb_top.sv]
// Self-checking bench for the subroutine-call execution block
`default_nettype none
module cscall_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, instr_valid, ext_valid, agu_ack, agu_has_ext, cond_true;
  logic        op_ack, op_growth, op_limit, busy, accept, agu_req, op_req, op_is_reg;
  logic        op_space_y, sp_inc, stack_push, pc_load, flag_we, scale_flag, limit_flag;
  logic [23:0] instr_word, instr_addr, ext_word, agu_ea, op_data, status_word, op_addr;
  logic [23:0] stack_high_word, stack_low_word, pc_value, pc_got, ssh_got, ssl_got, oa;
  logic [5:0]  effective_address_field, op_reg, org, eaf;
  logic [3:0]  cond_sel;
  logic        got_push, got_sp, got_flag, sf, lf, orr, oy;
  int          nagu;
  int          failures  = 0;
  int          tests_run = 0;

  cscall_exec i_dut (
    .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_addr(instr_addr), .ext_valid(ext_valid), .ext_word(ext_word),
    .agu_ack(agu_ack), .agu_ea(agu_ea), .agu_has_ext(agu_has_ext), .cond_true(cond_true),
    .op_ack(op_ack), .op_data(op_data), .op_growth(op_growth), .op_limit(op_limit),
    .status_word(status_word), .busy(busy), .accept(accept), .agu_req(agu_req),
    .effective_address_field(effective_address_field), .cond_sel(cond_sel),
    .op_req(op_req), .op_is_reg(op_is_reg), .op_space_y(op_space_y), .op_addr(op_addr),
    .op_reg(op_reg), .sp_inc(sp_inc), .stack_push(stack_push),
    .stack_high_word(stack_high_word), .stack_low_word(stack_low_word),
    .pc_load(pc_load), .pc_value(pc_value), .flag_we(flag_we),
    .scale_flag(scale_flag), .limit_flag(limit_flag));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Offers one opcode at a falling edge, answers address, operand and extension
  // requests after stall cycles, holding a second opcode up meanwhile
  task automatic run(input logic [23:0] w, a, ext, ea, opd, input logic hx, input int stall);
    int   n;
    logic pa, po, pf, done;
    n = 0; pa = 0; po = 0; pf = 0; done = 0;
    got_push = 0; got_sp = 0; got_flag = 0; nagu = 0;
    instr_word = w;
    instr_addr = a;
    instr_valid = 1'b1;
    @(negedge clk);
    chk(accept === 1'b1 && busy === 1'b1, "opcode not accepted");
    while (!done && n < 40) begin
      if (op_ack === 1'b1) op_data = ~op_data;
      if (ext_valid === 1'b1) ext_word = ~ext_word;
      agu_ack = 1'b0; op_ack = 1'b0; ext_valid = 1'b0;
      instr_valid = (n < stall);
      instr_word = 24'h0f0123;
      chk(n == 0 || accept !== 1'b1, "opcode taken while busy");
      if (agu_req === 1'b1) begin pa = 1; eaf = effective_address_field; end
      if (op_req === 1'b1) begin
        po = 1; oa = op_addr; oy = op_space_y; orr = op_is_reg; org = op_reg;
      end
      if (flag_we === 1'b1) begin pf = 1; got_flag = 1; sf = scale_flag; lf = limit_flag; end
      if (stack_push === 1'b1) begin
        got_push = 1; ssh_got = stack_high_word; ssl_got = stack_low_word;
      end
      if (sp_inc === 1'b1) got_sp = 1;
      if (pc_load === 1'b1) begin pc_got = pc_value; done = 1; end
      if (n >= stall) begin
        if (pa) begin agu_ack = 1; agu_ea = ea; agu_has_ext = hx; pa = 0; nagu++; end
        if (po) begin op_ack = 1; op_data = opd; po = 0; end
        if (pf) begin ext_valid = 1; ext_word = ext; pf = 0; end
      end
      n++;
      @(negedge clk);
    end
    chk(done, "no program counter load");
  endtask : run

  task automatic expect_end(input logic push, input logic [23:0] pc, ret);
    chk(got_push === push && got_sp === push, "stack push");
    chk(pc_got === pc, "program counter");
    if (push) chk(ssh_got === ret && ssl_got === status_word, "stacked words");
  endtask : expect_end

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ignore;
    logic [23:0] wd [2] = '{24'h0b05a3, 24'h0b2ae5};
    instr_valid = 1'b1;
    for (int i = 0; i < 2; i++) begin
      instr_word = wd[i];
      repeat (3) begin
        @(negedge clk);
        chk(accept !== 1'b1 && busy !== 1'b1, "foreign opcode taken");
      end
    end
    instr_valid = 1'b0;
    @(negedge clk);
  endtask : t_ignore

  task automatic t_short_call;
    status_word = 24'h5a3c81;
    cond_true = 1'b1;
    run(24'h0f3abc, 24'h000100, 24'h0, 24'h0, 24'h0, 1'b0, 0);
    chk(cond_sel === 4'h3 && got_flag === 1'b0, "condition or flags");
    expect_end(1'b1, 24'h000abc, 24'h000101);
    cond_true = 1'b0;
    run(24'h0f9fff, 24'h0007ff, 24'h0, 24'h0, 24'h0, 1'b0, 0);
    expect_end(1'b0, 24'h000800, 24'h0);
  endtask : t_short_call

  task automatic t_ea_call;
    status_word = 24'h3c00c3;
    cond_true = 1'b0;
    run(24'h0bc5a7, 24'h000200, 24'h0, 24'h123456, 24'h0, 1'b1, 0);
    chk(nagu == 1 && eaf === 6'h05 && cond_sel === 4'h7, "address update");
    expect_end(1'b0, 24'h000202, 24'h0);
    cond_true = 1'b1;
    run(24'h0bf0a2, 24'h000300, 24'h0, 24'h00a5a5, 24'h0, 1'b0, 0);
    chk(nagu == 1 && eaf === 6'h30 && got_flag === 1'b0, "address update");
    expect_end(1'b1, 24'h00a5a5, 24'h000301);
  endtask : t_ea_call

  task automatic t_clr_forms;
    logic [23:0] wd [5] = '{24'h0b2ac5, 24'h0b958f, 24'h01ffc0, 24'h0b6389, 24'h0bce0c};
    logic [23:0] ad [5] = '{24'h00002a, 24'hffffd5, 24'hffffbf, 24'h004321, 24'h000000};
    logic [23:0] od [5] = '{24'hffffdf, 24'h008000, 24'hfffffe, 24'h000200, 24'hffefff};
    logic [4:0]  tk = 5'b10101; // Tested bit clear
    logic [4:0]  sy = 5'b00101; // Y space operand
    logic [23:0] a, e;
    for (int i = 0; i < 5; i++) begin
      op_growth = i[0];
      op_limit = i[1];
      status_word = (i < 2) ? 24'h000040 : 24'h000080;
      a = 24'h001000 + 24'(i * 16);
      e = 24'h00c000 + 24'(i);
      run(wd[i], a, e, 24'h004321, od[i], 1'b0, i);
      chk(got_flag === 1'b1 && sf === (status_word[7] | op_growth)
          && lf === (status_word[6] | op_limit), "status flags");
      if (i == 4) chk(orr === 1'b1 && org === 6'h0e, "register source");
      else chk(oa === ad[i] && oy === sy[i] && orr === 1'b0, "operand address");
      chk(nagu == (i == 3) && (i != 3 || eaf === 6'h23), "address update");
      expect_end(tk[i], tk[i] ? e : a + 24'h2, a + 24'h2);
    end
  endtask : t_clr_forms

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {instr_valid, ext_valid, agu_ack, agu_has_ext, cond_true, op_ack} = '0;
    {op_growth, op_limit} = '0;
    {instr_word, instr_addr, ext_word, agu_ea, op_data, status_word} = '0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_ignore;
    t_short_call;
    t_ea_call;
    t_clr_forms;
    tally_and_finish;
  end

  initial begin
    #200000;
    failures++;
    tally_and_finish;
  end
endmodule : cscall_exec_tb_top
`default_nettype wire
